// ---- thc_pkg.sv ----
// Constants, command codes and decode helpers of the teleprinter host control
package thc_pkg;

  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_STOP = 4'h2;
  localparam logic [3:0] CMD_INHIBIT = 4'h4;
  localparam logic [3:0] CMD_READ_INH = 4'h5;
  localparam logic [3:0] CMD_STOP_INH = 4'h6;
  localparam logic [3:0] CMD_ALLOW = 4'h8;
  localparam logic [3:0] CMD_READ_ALW = 4'h9;
  localparam logic [3:0] CMD_STOP_ALW = 4'ha;

  // Stop windows in milliseconds, and clock rate in cycles per ms
  localparam int STOP_NEAR_MS = 22;
  localparam int STOP_FAR_MS = 33;
  localparam int STOP_IRQ_MS = 31;
  localparam int CYC_PER_MS = 250000;
  localparam int STOP_NEAR_CYC = STOP_NEAR_MS * CYC_PER_MS;
  localparam int STOP_FAR_CYC = STOP_FAR_MS * CYC_PER_MS;
  localparam int STOP_IRQ_CYC = STOP_IRQ_MS * CYC_PER_MS;
  localparam int AGE_W = 24;

  localparam logic RESET_TX_SERVICE = 1'b1;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;

  function automatic logic cmd_is_start(input logic [3:0] n);
    return (n == CMD_READ) || (n == CMD_READ_INH) || (n == CMD_READ_ALW);
  endfunction

  function automatic logic cmd_is_stop(input logic [3:0] n);
    return (n == CMD_STOP) || (n == CMD_STOP_INH) || (n == CMD_STOP_ALW);
  endfunction

  function automatic logic cmd_is_inhibit(input logic [3:0] n);
    return (n == CMD_INHIBIT) || (n == CMD_READ_INH) || (n == CMD_STOP_INH);
  endfunction

  function automatic logic cmd_is_allow(input logic [3:0] n);
    return (n == CMD_ALLOW) || (n == CMD_READ_ALW) || (n == CMD_STOP_ALW);
  endfunction

endpackage

// ---- thc_stream_if.sv ----
// Valid/ready byte stream between the control logic and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface thc_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- thc_fifo.sv ----
// Byte FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module thc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  thc_stream_if.snk wr,
  thc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic out_valid;
  logic [WIDTH-1:0] out_data;
  logic do_push;
  logic do_load;

  // Output register counts as one extra slot beyond the array
  assign wr.ready = (count != FULL_CNT);
  assign do_push = wr.valid && wr.ready;
  assign do_load = (count != '0) && (!out_valid || rd.ready);
  assign rd.valid = out_valid;
  assign rd.data = out_data;

  // Array write
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr] <= wr.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_load) begin
        rptr <= rptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_load};
    end
  end

  // Read data always comes from this register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (do_load) begin
      out_valid <= 1'b1;
      out_data <= mem[rptr];
    end else if (rd.ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- thc_top.sv ----
// Host-side control of a full-duplex teleprinter controller
`timescale 1ns/1ps
`default_nettype none
module thc_top #(
  parameter int STOP_NEAR_CYC = thc_pkg::STOP_NEAR_CYC,
  parameter int STOP_FAR_CYC = thc_pkg::STOP_FAR_CYC,
  parameter int STOP_IRQ_CYC = thc_pkg::STOP_IRQ_CYC,
  parameter int FIFO_DEPTH = thc_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // Station address of the transmitter, bit 0 ignored; receiver is the next odd one
  input wire logic [7:0] station_addr_i,
  // Programmed channel bus side
  input wire logic [7:0] sel_addr_i,
  input wire logic command_output_instr_i,
  input wire logic data_input_instr_i,
  input wire logic data_output_instr_i,
  input wire logic address_input_instr_i,
  input wire logic [7:0] bus_data_i,
  output logic [7:0] bus_data_o,
  output logic bus_data_oe_o,
  output logic ack_o,
  output logic rx_irq_o,
  output logic tx_irq_o,
  // Receiver character side
  input wire logic rx_char_start_i,
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic tape_loaded_i,
  input wire logic on_line_i,
  input wire logic lever_start_i,
  input wire logic kbd_busy_i,
  output logic reader_run_o,
  // Transmitter character side
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic tx_unit9_i,
  input wire logic tx_done_i
);
  localparam int AW = thc_pkg::AGE_W;

  logic [7:0] tx_addr;
  logic [7:0] rx_addr;
  logic rx_hit;
  logic tx_hit;
  logic [3:0] cmd_nib;
  logic rx_cmd_ok;
  logic tx_cmd_ok;
  logic rx_inh;
  logic rx_alw;
  logic tx_inh;
  logic tx_alw;
  logic rx_start;
  logic rx_stop;
  logic edi_ok;
  logic edo_ok;
  logic eai_rx;
  logic eai_tx;

  logic [7:0] rx_buf;
  logic rx_full;
  logic rx_irq_en;
  logic tx_irq_en;
  logic tx_service;
  logic [1:0] stop_left;
  logic [1:0] next_stop_left;
  logic [AW-1:0] ack_age;
  logic [AW-1:0] irq_age;

  thc_stream_if #(.WIDTH(thc_pkg::BYTE_W)) push_if ();
  thc_stream_if #(.WIDTH(thc_pkg::BYTE_W)) pop_if ();

  // Section addresses from the strap
  // even and odd
  assign tx_addr = {station_addr_i[7:1], 1'b0};
  assign rx_addr = {station_addr_i[7:1], 1'b1};
  assign rx_hit = (sel_addr_i == rx_addr);
  assign tx_hit = (sel_addr_i == tx_addr);

  // Command decode; upper digits are don't-care
  // low nibble only
  assign cmd_nib = bus_data_i[3:0];
  assign rx_cmd_ok = command_output_instr_i && rx_hit &&
                     (thc_pkg::cmd_is_start(cmd_nib) ||
                      thc_pkg::cmd_is_stop(cmd_nib) ||
                      (cmd_nib == thc_pkg::CMD_INHIBIT) ||
                      (cmd_nib == thc_pkg::CMD_ALLOW));
  // transmitter takes only inhibit and allow
  assign tx_cmd_ok = command_output_instr_i && tx_hit &&
                     ((cmd_nib == thc_pkg::CMD_INHIBIT) ||
                      (cmd_nib == thc_pkg::CMD_ALLOW));
  assign rx_inh = rx_cmd_ok && thc_pkg::cmd_is_inhibit(cmd_nib);
  assign rx_alw = rx_cmd_ok && thc_pkg::cmd_is_allow(cmd_nib);
  assign tx_inh = tx_cmd_ok && (cmd_nib == thc_pkg::CMD_INHIBIT);
  assign tx_alw = tx_cmd_ok && (cmd_nib == thc_pkg::CMD_ALLOW);
  assign rx_start = rx_cmd_ok && thc_pkg::cmd_is_start(cmd_nib);
  assign rx_stop = rx_cmd_ok && thc_pkg::cmd_is_stop(cmd_nib);

  // Data-in is refused when a new character is already under way
  // drop and stay silent
  assign edi_ok = data_input_instr_i && rx_hit && rx_full &&
                  !rx_char_start_i;
  assign edo_ok = data_output_instr_i && tx_hit && tx_service &&
                  push_if.ready;
  // Address-in serves receiver first when both request
  // requesting section only
  assign eai_rx = address_input_instr_i && rx_irq_o;
  assign eai_tx = address_input_instr_i && tx_irq_o && !rx_irq_o;

  // Bus answer, registered, one cycle after the strobe
  // acknowledge for commands and data; address-in gets none
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      bus_data_o <= 8'h00;
      bus_data_oe_o <= 1'b0;
    end else begin
      ack_o <= rx_cmd_ok || tx_cmd_ok || edi_ok || edo_ok;
      bus_data_oe_o <= edi_ok || eai_rx || eai_tx;
      if (edi_ok) begin
        bus_data_o <= rx_buf;
      end else if (eai_rx) begin
        bus_data_o <= rx_addr;
      end else if (eai_tx) begin
        bus_data_o <= tx_addr;
      end else begin
        bus_data_o <= 8'h00;
      end
    end
  end

  // Receiver holding byte and service-required state
  // data-in clears service state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (edi_ok || rx_char_start_i) begin
        rx_full <= 1'b0;
      end
      // New character wins over a same-cycle clear
      if (rx_char_valid_i) begin
        rx_buf <= rx_char_i;
        rx_full <= 1'b1;
      end
    end
  end

  // Receiver interrupt allow bit
  // starts suppressed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_irq_en <= 1'b0;
    end else if (rx_inh) begin
      rx_irq_en <= 1'b0;
    end else if (rx_alw) begin
      rx_irq_en <= 1'b1;
    end
  end

  // Receiver interrupt request
  // per character until serviced
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_irq_o <= 1'b0;
    end else begin
      if (edi_ok || eai_rx || rx_char_start_i) begin
        rx_irq_o <= 1'b0;
      end
      if (rx_inh) begin
        rx_irq_o <= 1'b0;
      end
      if (rx_alw) begin
        rx_irq_o <= rx_full && !edi_ok && !rx_char_start_i;
      end
      // Set wins over every clear above except a same-cycle inhibit
      if (rx_char_valid_i && (rx_alw || (rx_irq_en && !rx_inh))) begin
        rx_irq_o <= 1'b1;
      end
    end
  end

  // Time since last data-in acknowledge, saturating
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_age <= '1;
    end else if (edi_ok) begin
      ack_age <= '0;
    end else if (ack_age != '1) begin
      ack_age <= ack_age + 1'b1;
    end
  end

  // Time since the receiver request was raised, saturating
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_age <= '1;
    end else if (rx_char_valid_i && rx_irq_en) begin
      irq_age <= '0;
    end else if (irq_age != '1) begin
      irq_age <= irq_age + 1'b1;
    end
  end

  // Characters still to pass before a stop takes hold
  // inhibited stop window
  always_comb begin
    next_stop_left = stop_left;
    if (rx_irq_en) begin
      next_stop_left = (irq_age <= AW'(STOP_IRQ_CYC)) ? 2'd2 : 2'd1;
    end else if (ack_age <= AW'(STOP_NEAR_CYC)) begin
      next_stop_left = 2'd1;
    end else begin
      // Gap between the two windows treated like the late case
      next_stop_left = (ack_age > AW'(STOP_FAR_CYC)) ? 2'd2 : 2'd2;
    end
  end

  // Reader run control
  // reader inhibited at reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reader_run_o <= 1'b0;
      stop_left <= 2'd0;
    end else if (rx_start) begin
      if (tape_loaded_i && on_line_i && lever_start_i && !kbd_busy_i) begin
        reader_run_o <= 1'b1;
      end
      stop_left <= 2'd0;
    end else if (rx_stop && reader_run_o) begin
      stop_left <= next_stop_left;
    end else if (rx_char_valid_i && (stop_left != 2'd0)) begin
      stop_left <= stop_left - 2'd1;
      if (stop_left == 2'd1) begin
        reader_run_o <= 1'b0;
      end
    end
  end

  // Transmitter interrupt allow bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_irq_en <= 1'b0;
    end else if (tx_inh) begin
      tx_irq_en <= 1'b0;
    end else if (tx_alw) begin
      tx_irq_en <= 1'b1;
    end
  end

  // Transmitter service-required state
  // transmitter needs service
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_service <= thc_pkg::RESET_TX_SERVICE;
    end else begin
      if (edo_ok || eai_tx) begin
        tx_service <= 1'b0;
      end
      // Completion beats a same-cycle clear
      if (tx_done_i) begin
        tx_service <= 1'b1;
      end
    end
  end

  // Transmitter interrupt request
  // raised after eighth bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_irq_o <= 1'b0;
    end else begin
      if (edo_ok || eai_tx || tx_inh) begin
        tx_irq_o <= 1'b0;
      end
      if (tx_alw) begin
        tx_irq_o <= tx_service && !edo_ok;
      end
      if (tx_unit9_i && (tx_alw || (tx_irq_en && !tx_inh))) begin
        tx_irq_o <= 1'b1;
      end
    end
  end

  // Accepted bytes queue toward the serialiser
  assign push_if.valid = edo_ok;
  assign push_if.data = bus_data_i;

  thc_fifo #(
    .WIDTH(thc_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr(push_if),
    .rd(pop_if)
  );

  // Output stage; a stalled serialiser backs up into the FIFO
  assign pop_if.ready = !tx_valid_o || tx_ready_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (pop_if.ready) begin
      tx_valid_o <= pop_if.valid;
      if (pop_if.valid) begin
        tx_data_o <= pop_if.data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- thc_top_dummy_end.sv ----
// Intentionally minimal: empty compilation unit guard
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- thc_checker.sv ----
// Port-level assertions for the teleprinter host control
`timescale 1ns/1ps
`default_nettype none
module thc_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] station_addr_i,
  input wire logic [7:0] sel_addr_i,
  input wire logic command_output_instr_i,
  input wire logic data_input_instr_i,
  input wire logic data_output_instr_i,
  input wire logic address_input_instr_i,
  input wire logic [7:0] bus_data_i,
  input wire logic bus_data_oe_o,
  input wire logic ack_o,
  input wire logic rx_irq_o,
  input wire logic tx_irq_o,
  input wire logic rx_char_start_i,
  input wire logic rx_char_valid_i,
  input wire logic reader_run_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [3:0] nib;
  logic cmd_rx;
  logic cmd_tx;
  logic good;
  logic tx_good;
  logic any_req;
  logic din_rx;
  // Decode helpers; bit 0 of the selected address picks the section, bit 0 of the strap is ignored
  assign nib = bus_data_i[3:0];
  assign cmd_rx = command_output_instr_i &&
    sel_addr_i == {station_addr_i[7:1], 1'b1};
  assign cmd_tx = command_output_instr_i &&
    sel_addr_i == {station_addr_i[7:1], 1'b0};
  assign good = nib inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
  // Held in a helper so the past value is of a plain signal
  assign tx_good = nib inside {4'h4, 4'h8};
  assign any_req = command_output_instr_i || data_input_instr_i ||
    data_output_instr_i;
  // Only a data-in aimed at the receiver counts as its service
  assign din_rx = data_input_instr_i &&
    sel_addr_i == {station_addr_i[7:1], 1'b1};
  a_rx_cmd_ack: assert property (cmd_rx && good |=> ack_o)
    else $error("valid receiver command not acknowledged");
  a_bad_cmd_quiet: assert property (cmd_rx && !good |=> !ack_o)
    else $error("invalid command acknowledged");
  a_tx_cmd_set: assert property (cmd_tx |=> ack_o == $past(tx_good))
    else $error("transmitter command answer wrong");
  a_ack_cause: assert property (ack_o |-> $past(any_req))
    else $error("acknowledge without request");
  a_addr_no_ack: assert property (address_input_instr_i |=> !ack_o)
    else $error("address-in acknowledged");
  a_start_drops: assert property (data_input_instr_i && rx_char_start_i
    |=> !ack_o && !bus_data_oe_o)
    else $error("data-in answered during new character");
  a_inh_drops: assert property (cmd_rx && nib == 4'h4 |=> !rx_irq_o)
    else $error("receiver request survived inhibit");
  a_din_clears: assert property (din_rx && !rx_char_valid_i
    |=> !rx_irq_o)
    else $error("receiver request survived data-in");
  a_reset_quiet: assert property ($fell(reset_i)
    |-> !rx_irq_o && !tx_irq_o && !reader_run_o)
    else $error("outputs not quiet after reset");
  c_din_ack: cover property (data_input_instr_i ##1 ack_o);
  c_ain_drive: cover property (address_input_instr_i ##1 bus_data_oe_o);
  c_reader_stop: cover property ($fell(reader_run_o));
endmodule
bind thc_top thc_checker chk (.clk_i(clk_i), .reset_i(reset_i),
  .station_addr_i(station_addr_i), .sel_addr_i(sel_addr_i),
  .command_output_instr_i(command_output_instr_i),
  .data_input_instr_i(data_input_instr_i),
  .data_output_instr_i(data_output_instr_i),
  .address_input_instr_i(address_input_instr_i), .bus_data_i(bus_data_i),
  .bus_data_oe_o(bus_data_oe_o), .ack_o(ack_o), .rx_irq_o(rx_irq_o),
  .tx_irq_o(tx_irq_o), .rx_char_start_i(rx_char_start_i),
  .rx_char_valid_i(rx_char_valid_i), .reader_run_o(reader_run_o));
`default_nettype wire

// ---- thc_serial_model.sv ----
// Behavioural serialiser draining transmit bytes toward the printer
`timescale 1ns/1ps
`default_nettype none
module thc_serial_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tx_valid_i,
  input wire logic stall_i,
  output logic tx_ready_o,
  output logic tx_unit9_o,
  output logic tx_done_o
);
  int cnt;
  // Ready only when idle; stall lets the bench slow the far side
  assign tx_ready_o = cnt == 0 && !stall_i && !reset_i;
  // Frame timer, shortened; unit nine comes before the end
  always_ff @(posedge clk_i) begin
    tx_unit9_o <= 1'b0;
    tx_done_o <= 1'b0;
    if (reset_i) begin
      cnt <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      cnt <= 24;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      tx_unit9_o <= cnt == 6;
      tx_done_o <= cnt == 1;
    end
  end
endmodule
`default_nettype wire

// ---- teleprinter_host_control_test.sv ----
// Self-checking bench for the teleprinter host control
`timescale 1ns/1ps
`default_nettype none
module teleprinter_host_control_test;
  localparam logic [7:0] TXA = 8'h42;
  localparam logic [7:0] RXA = 8'h43;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] stb = 4'h0;
  logic [7:0] sel = 8'h00;
  logic [7:0] bdi = 8'h00;
  logic [1:0] ev = 2'h0;
  logic [7:0] rxc = 8'h00;
  logic kbd = 1'b1;
  // Tape loaded, on line, lever at start
  logic [2:0] cond = 3'b111;
  logic stall = 1'b0;
  logic [7:0] bdo;
  logic [7:0] txd;
  logic oe, ack, rxi, txi, run, txv, rdy, u9, done;
  logic g_ack, g_oe;
  logic [7:0] g_bus;
  logic [7:0] b;
  logic [31:0] seed = 32'head100bb;
  logic [7:0] txq[$];
  int err_count = 0;
  int samples_checked = 0;
  // Short stop windows keep the run brief
  thc_top #(.STOP_NEAR_CYC(40), .STOP_FAR_CYC(60), .STOP_IRQ_CYC(55)) dut (
    .clk_i(clk), .reset_i(reset), .station_addr_i(TXA), .sel_addr_i(sel),
    .command_output_instr_i(stb[3]), .data_input_instr_i(stb[2]),
    .data_output_instr_i(stb[1]), .address_input_instr_i(stb[0]),
    .bus_data_i(bdi), .bus_data_o(bdo), .bus_data_oe_o(oe), .ack_o(ack),
    .rx_irq_o(rxi), .tx_irq_o(txi), .rx_char_start_i(ev[1]),
    .rx_char_valid_i(ev[0]), .rx_char_i(rxc), .tape_loaded_i(cond[2]),
    .on_line_i(cond[1]), .lever_start_i(cond[0]), .kbd_busy_i(kbd),
    .reader_run_o(run), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_ready_i(rdy), .tx_unit9_i(u9), .tx_done_i(done));
  thc_serial_model far (.clk_i(clk), .reset_i(reset), .tx_valid_i(txv),
    .stall_i(stall), .tx_ready_o(rdy), .tx_unit9_o(u9), .tx_done_o(done));
  initial forever #2 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Expected acknowledge of a command per section
  function automatic logic cmd_ok(input logic [3:0] n, input logic rx);
    if (rx) return n inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
    return n inside {4'h4, 4'h8};
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // One bus instruction; answer captured once it has landed
  // idle cycle between instructions
  task automatic op(input int k, input logic [7:0] s, input logic [7:0] d);
    @(posedge clk);
    stb <= 4'h8 >> k;
    sel <= s;
    bdi <= d;
    @(posedge clk);
    stb <= 4'h0;
    #1;
    g_ack = ack;
    g_oe = oe;
    g_bus = bdo;
  endtask
  task automatic pulse(input logic [1:0] v, input logic [7:0] c);
    @(posedge clk);
    ev <= v;
    rxc <= c;
    @(posedge clk);
    ev <= 2'b00;
  endtask
  task automatic char_in(input logic [7:0] c);
    pulse(2'b10, c);
    pulse(2'b01, c);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (done) return;
    end
    chk1(1'b0, 1'b1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bytes leaving for the printer follow acceptance order
  always @(posedge clk) begin
    if (txv && rdy) chk8(txd, txq.pop_front());
  end
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1 chk1(txi, 1'b0);
    op(0, RXA, 8'h01);
    chk1(run, 1'b0);
    kbd <= 1'b0;
    // Each missing start condition alone keeps the reader off
    for (int i = 0; i < 3; i++) begin
      cond <= 3'b111 ^ (3'b001 << i);
      op(0, RXA, 8'h01);
      chk1(run, 1'b0);
    end
    cond <= 3'b111;
    // Every code to both sections, upper digits random
    for (int s = 0; s < 2; s++) begin
      for (int n = 0; n < 16; n++) begin
        op(0, s ? TXA : RXA, (rnd() & 8'hf0) | 8'(n));
        chk1(g_ack, cmd_ok(4'(n), s == 0));
      end
    end
    chk1(txi, 1'b1);
    op(0, TXA, 8'h04);
    chk1(txi, 1'b0);
    // valid codes only from here on
    // Late stop: two more characters
    op(0, RXA, 8'h05);
    chk1(run, 1'b1);
    op(0, RXA, 8'h02);
    char_in(rnd());
    #1 chk1(run, 1'b1);
    char_in(rnd());
    #1 chk1(run, 1'b0);
    // Early stop after a data-in: one more character
    op(0, RXA, 8'h01);
    b = rnd();
    char_in(b);
    op(1, RXA, 8'h00);
    chk8(g_bus, b);
    chk1(g_ack, 1'b1);
    op(1, RXA, 8'h00);
    chk1(g_ack | g_oe, 1'b0);
    op(0, RXA, 8'h02);
    char_in(rnd());
    #1 chk1(run, 1'b0);
    // Data-in in the very cycle a new character begins
    fork
      op(1, RXA, 8'h00);
      pulse(2'b10, 8'h00);
    join
    chk1(g_ack | g_oe, 1'b0);
    pulse(2'b10, 8'h00);
    op(1, RXA, 8'h00);
    chk1(g_ack, 1'b0);
    // Random characters with interrupts allowed
    op(0, RXA, 8'h08);
    for (int i = 0; i < 8; i++) begin
      b = rnd();
      char_in(b);
      #1 chk1(rxi, 1'b1);
      if (b[0]) begin
        op(0, RXA, 8'h04);
        chk1(rxi, 1'b0);
        op(0, RXA, 8'h08);
        chk1(rxi, 1'b1);
      end
      if (b[1]) begin
        op(3, RXA, 8'h00);
        chk8(g_bus, RXA);
        chk1(g_ack | rxi, 1'b0);
      end
      op(1, RXA, 8'h00);
      chk8(g_bus, b);
      chk1(rxi, 1'b0);
    end
    // Allowed stop soon after a request: two more characters
    op(0, RXA, 8'h09);
    chk1(run, 1'b1);
    char_in(rnd());
    op(0, RXA, 8'h0a);
    char_in(rnd());
    #1 chk1(run, 1'b1);
    char_in(rnd());
    #1 chk1(run, 1'b0);
    // Serve the last byte so address-in below sees no receiver request
    op(1, RXA, 8'h00);
    chk1(rxi, 1'b0);
    // Inhibited transmitter with a stalled far side
    stall <= 1'b1;
    b = rnd();
    txq.push_back(b);
    op(2, TXA, b);
    chk1(g_ack, 1'b1);
    op(2, TXA, ~b);
    chk1(g_ack, 1'b0);
    repeat (5) @(posedge clk);
    stall <= 1'b0;
    wait_done();
    chk1(txi, 1'b0);
    op(3, TXA, 8'h00);
    chk1(g_oe, 1'b0);
    op(0, TXA, 8'h08);
    chk1(txi, 1'b1);
    b = rnd();
    txq.push_back(b);
    op(2, TXA, b);
    chk1(g_ack, 1'b1);
    chk1(txi, 1'b0);
    wait_done();
    chk1(txi, 1'b1);
    op(3, TXA, 8'h00);
    chk8(g_bus, TXA);
    chk1(g_ack | txi, 1'b0);
    chk1(txq.size() == 0, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
